// >>> rtl/dts_pkg.sv
// Function
// - write data sampled on both input clock rises
// - read data launched on output clock rises, on input clock rises in single-clock mode
// - data pins released whenever no read word
// - every access moves exactly two words
// - active-low lane selects sampled, unselected bytes kept
// - each lane select pairs with its data word
// - one shared address bus for reads, writes
// - start bit loads one-bit linear burst counter
// - default organisation uses twenty address inputs
// - address ignored unless request strobe low
// - direction high reads, low writes
// - accesses and controls captured on positive rise
// - negative rise captures second word and its lane selects
// - two echo strobes run free outside reset, held low in reset
// - single-clock mode echoes follow input clocks
// - latency 1.5 cycles, or 1 when loop disabled
package dts_pkg;

  // ==========================================================
  // organisation
  localparam int DTS_LANE_W      = 9;                        // bits per byte lane
  localparam int DTS_LANES       = 4;                        // byte lanes of the wide organisation
  localparam int DTS_ADDR_W      = 20;                       // address inputs, burst bit included
  localparam int DTS_BURST_LEN   = 2;                        // words per access

  // ==========================================================
  // read latency, counted in launch clock rises after the request (input clock rises in single-clock mode)
  localparam int DTS_LAT_LOOP_ON  = 3;                       // one and a half cycles
  localparam int DTS_LAT_LOOP_OFF = 2;                       // one cycle
  localparam int DTS_SCHED_DEPTH  = DTS_LAT_LOOP_ON + DTS_BURST_LEN - 1;

  // ==========================================================
  // pin encodings
  localparam logic DTS_DIR_READ  = 1'b1;                     // direction level for a read
  localparam logic DTS_LANE_ON   = 1'b0;                     // active-low lane select level
  localparam logic DTS_REQ_ON    = 1'b0;                     // active-low request level

  // ==========================================================
  // write burst state
  typedef enum logic [1:0] {
    DTS_WR_IDLE   = 2'b01,                                   // no write in progress
    DTS_WR_SECOND = 2'b10                                    // waiting for the second word
  } dts_wr_e;

endpackage

// >>> rtl/dts_sram_core.sv
// ==========================================================
// storage array: one lane-masked write port, two read ports
module dts_sram_core
  import dts_pkg::*;
#(
  parameter int LANE_W = DTS_LANE_W,
  parameter int LANES  = DTS_LANES,
  parameter int ADDR_W = DTS_ADDR_W
) (
  // clock
  input  wire logic                      i_mclk,
  // write port
  input  wire logic [LANES-1:0]          i_wr_lane_en,
  input  wire logic [ADDR_W-1:0]         i_wr_addr,
  input  wire logic [LANE_W*LANES-1:0]   i_wr_data,
  // read ports
  input  wire logic [ADDR_W-1:0]         i_rd_addr0,
  input  wire logic [ADDR_W-1:0]         i_rd_addr1,
  output logic      [LANE_W*LANES-1:0]   o_rd_data0,
  output logic      [LANE_W*LANES-1:0]   o_rd_data1
);

  logic [LANE_W*LANES-1:0] mem [2**ADDR_W];                  // word array

  // ==========================================================
  // lane-masked write, lanes left out keep their contents
  always_ff @(posedge i_mclk) begin
    for (int l = 0; l < LANES; l++) begin
      if (i_wr_lane_en[l]) begin
        mem[i_wr_addr][l*LANE_W +: LANE_W] <= i_wr_data[l*LANE_W +: LANE_W];
      end
    end
  end

  // ==========================================================
  // both burst words read at once
  always_comb begin
    o_rd_data0 = mem[i_rd_addr0];
    o_rd_data1 = mem[i_rd_addr1];
  end

endmodule

// >>> rtl/dts_sram_port.sv
// ==========================================================
// double-data-rate two-word burst memory port
module dts_sram_port
  import dts_pkg::*;
#(
  parameter int LANE_W = DTS_LANE_W,
  parameter int LANES  = DTS_LANES,
  parameter int ADDR_W = DTS_ADDR_W
) (
  // system clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_reset,
  // link clocks
  input  wire logic                      i_k,
  input  wire logic                      i_k_n,
  input  wire logic                      i_c,
  input  wire logic                      i_c_n,
  // mode pins
  input  wire logic                      i_single_clock,
  input  wire logic                      i_pll_disable_n,
  // request
  input  wire logic                      i_cycle_request_n,
  input  wire logic                      i_rw,
  input  wire logic [ADDR_W-2:0]         i_addr_upper,
  input  wire logic                      i_burst_start_bit,
  // write data
  input  wire logic [LANES-1:0]          i_byte_lane_select_n,
  input  wire logic [LANE_W*LANES-1:0]   i_dq,
  // read data
  output logic      [LANE_W*LANES-1:0]   o_dq,
  output logic                           o_dq_oe,
  // echo strobes
  output logic                           o_returned_strobe_pos,
  output logic                           o_returned_strobe_neg
);

  localparam int DATA_W = LANE_W * LANES;                    // data bus width
  localparam int SYNC_W = 9 + (ADDR_W - 1) + LANES + DATA_W; // all pins that are synchronised

  // ==========================================================
  // pin synchroniser
  logic [SYNC_W-1:0] pin_raw;                                // pins as they arrive
  logic [SYNC_W-1:0] pin_meta;                               // first stage, read by second only
  logic [SYNC_W-1:0] pin_sync;                               // second stage
  logic              s_k;                                    // synced positive input clock
  logic              s_k_n;                                  // synced negative input clock
  logic              s_c;                                    // synced positive output clock
  logic              s_c_n;                                  // synced negative output clock
  logic              s_req_n;                                // synced request strobe
  logic              s_rw;                                   // synced direction
  logic              s_a0;                                   // synced burst start bit
  logic              s_loop_n;                               // synced loop-disable pin
  logic              s_single;                               // synced single-clock strap
  logic [ADDR_W-2:0] s_addr;                                 // synced upper address
  logic [LANES-1:0]  s_bws_n;                                // synced lane selects
  logic [DATA_W-1:0] s_dq;                                   // synced data

  assign pin_raw = {i_k, i_k_n, i_c, i_c_n, i_cycle_request_n, i_rw, i_burst_start_bit,
                    i_pll_disable_n, i_single_clock, i_addr_upper, i_byte_lane_select_n, i_dq};
  assign {s_k, s_k_n, s_c, s_c_n, s_req_n, s_rw, s_a0, s_loop_n, s_single, s_addr,
          s_bws_n, s_dq} = pin_sync;

  // two flops on every pin, no reset needed
  always_ff @(posedge i_mclk) begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
  end

  // ==========================================================
  // clock edge detection
  logic [3:0] clk_prev;                                      // last synced clock levels
  logic       k_rise;                                        // positive input rise
  logic       kn_rise;                                       // negative input rise
  logic       out_pos_rise;                                  // rise of the positive launch clock
  logic       out_neg_rise;                                  // rise of the negative launch clock
  logic       out_edge;                                      // any launch rise

  // history tracks the pins through reset as well, so its release shows no false rise
  always_ff @(posedge i_mclk) begin
    clk_prev <= {s_k, s_k_n, s_c, s_c_n};
  end

  always_comb begin
    k_rise       = s_k & ~clk_prev[3];
    kn_rise      = s_k_n & ~clk_prev[2];
    // single-clock mode launches on the input pair
    out_pos_rise = s_single ? k_rise : (s_c & ~clk_prev[1]);
    out_neg_rise = s_single ? kn_rise : (s_c_n & ~clk_prev[0]);
    out_edge     = out_pos_rise | out_neg_rise;
  end

  // ==========================================================
  // request decode
  logic req;                                                 // access starts this cycle
  logic req_rd;                                              // read access
  logic req_wr;                                              // write access

  always_comb begin
    // strobe only looked at on the positive rise, address ignored otherwise
    req    = k_rise & (s_req_n == DTS_REQ_ON);
    req_rd = req & (s_rw == DTS_DIR_READ);
    req_wr = req & (s_rw != DTS_DIR_READ);
  end

  // lane write enables from active-low selects
  function automatic logic [LANES-1:0] lane_sel(input logic [LANES-1:0] bws_n);
    logic [LANES-1:0] en;
    en = '0;
    for (int l = 0; l < LANES; l++) begin
      en[l] = (bws_n[l] == DTS_LANE_ON);
    end
    return en;
  endfunction

  // ==========================================================
  // write burst
  dts_wr_e           wr_state;                               // burst position
  dts_wr_e           next_wr_state;
  logic [ADDR_W-2:0] wr_hi;                                  // held upper address
  logic [ADDR_W-2:0] next_wr_hi;
  logic              wr_cnt;                                 // one-bit burst counter
  logic              next_wr_cnt;
  logic [LANES-1:0]  wr_lane_en;                             // lanes written this cycle
  logic [ADDR_W-1:0] wr_addr;                                // word written this cycle

  always_comb begin
    next_wr_state = wr_state;
    next_wr_hi    = wr_hi;
    next_wr_cnt   = wr_cnt;
    wr_lane_en    = '0;
    wr_addr       = {wr_hi, wr_cnt};
    case (wr_state)
      DTS_WR_IDLE: begin
        next_wr_state = DTS_WR_IDLE;
      end
      DTS_WR_SECOND: begin
        // second word and its selects taken on the negative rise
        if (kn_rise) begin
          wr_lane_en    = lane_sel(s_bws_n);
          next_wr_state = DTS_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = DTS_WR_IDLE;
      end
    endcase
    if (req_wr) begin
      // first word with its selects on the positive rise
      wr_lane_en    = lane_sel(s_bws_n);
      wr_addr       = {s_addr, s_a0};
      next_wr_hi    = s_addr;
      next_wr_cnt   = ~s_a0;
      next_wr_state = DTS_WR_SECOND;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_state <= DTS_WR_IDLE;
      wr_hi    <= '0;
      wr_cnt   <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      wr_hi    <= next_wr_hi;
      wr_cnt   <= next_wr_cnt;
    end
  end

  // ==========================================================
  // storage
  logic [DATA_W-1:0] rd_word0;                               // first burst word
  logic [DATA_W-1:0] rd_word1;                               // second burst word

  dts_sram_core #(
    .LANE_W (LANE_W),
    .LANES  (LANES),
    .ADDR_W (ADDR_W)
  ) u_core (
    .i_mclk       (i_mclk),
    .i_wr_lane_en (wr_lane_en),
    .i_wr_addr    (wr_addr),
    .i_wr_data    (s_dq),
    .i_rd_addr0   ({s_addr, s_a0}),
    .i_rd_addr1   ({s_addr, ~s_a0}),
    .o_rd_data0   (rd_word0),
    .o_rd_data1   (rd_word1)
  );

  // ==========================================================
  // read schedule, slot 0 is the next launch rise
  logic [DATA_W-1:0] sched_d [DTS_SCHED_DEPTH];              // queued words
  logic [DATA_W-1:0] next_sched_d [DTS_SCHED_DEPTH];
  logic [DTS_SCHED_DEPTH-1:0] sched_v;                       // slot holds a word
  logic [DTS_SCHED_DEPTH-1:0] next_sched_v;
  logic [DATA_W-1:0] next_dq;
  logic              next_dq_oe;

  always_comb begin
    int base;
    base         = (s_loop_n ? DTS_LAT_LOOP_ON : DTS_LAT_LOOP_OFF) - 1;
    next_sched_d = sched_d;
    next_sched_v = sched_v;
    next_dq      = o_dq;
    next_dq_oe   = o_dq_oe;
    if (out_edge) begin
      // launch slot 0; an empty slot releases the pins
      next_dq    = sched_d[0];
      next_dq_oe = sched_v[0];
      for (int i = 0; i < DTS_SCHED_DEPTH - 1; i++) begin
        next_sched_d[i] = sched_d[i+1];
        next_sched_v[i] = sched_v[i+1];
      end
      next_sched_d[DTS_SCHED_DEPTH-1] = '0;
      next_sched_v[DTS_SCHED_DEPTH-1] = 1'b0;
    end
    if (req_rd) begin
      // both words queued on consecutive launch rises
      next_sched_d[base]   = rd_word0;
      next_sched_v[base]   = 1'b1;
      next_sched_d[base+1] = rd_word1;
      next_sched_v[base+1] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sched_d <= '{default: '0};
      sched_v <= '0;
      o_dq    <= '0;
      o_dq_oe <= 1'b0;
    end else begin
      sched_d <= next_sched_d;
      sched_v <= next_sched_v;
      o_dq    <= next_dq;
      o_dq_oe <= next_dq_oe;
    end
  end

  // ==========================================================
  // echo strobes, free running whatever the traffic
  logic next_echo_pos;
  logic next_echo_neg;

  always_comb begin
    next_echo_pos = s_single ? s_k : s_c;
    next_echo_neg = s_single ? s_k_n : s_c_n;
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_returned_strobe_pos <= 1'b0;
      o_returned_strobe_neg <= 1'b0;
    end else begin
      o_returned_strobe_pos <= next_echo_pos;
      o_returned_strobe_neg <= next_echo_neg;
    end
  end

endmodule

// >>> dv/dts_sram_port_monitor.sv
// ==========================================================
// port checker: echo strobes, read timing and bus release
module dts_sram_port_monitor
  import dts_pkg::*;
#(
  parameter int LANE_W = DTS_LANE_W,
  parameter int LANES  = DTS_LANES
) (
  // clock and reset
  input wire logic                    i_mclk,
  input wire logic                    i_reset,
  // link clocks and mode pins
  input wire logic                    i_k,
  input wire logic                    i_k_n,
  input wire logic                    i_c,
  input wire logic                    i_c_n,
  input wire logic                    i_single_clock,
  input wire logic                    i_pll_disable_n,
  // request
  input wire logic                    i_cycle_request_n,
  input wire logic                    i_rw,
  // port outputs
  input wire logic [LANE_W*LANES-1:0] o_dq,
  input wire logic                    o_dq_oe,
  input wire logic                    o_returned_strobe_pos,
  input wire logic                    o_returned_strobe_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helpers
  logic [3:0]              settle, next_settle;   // cycles since reset, saturating
  logic [31:0]             rd_hist, next_rd_hist; // read requests, bit n seen n+1 cycles ago
  logic [5:0]              oe_run, next_oe_run;   // length of the drive run
  logic [2:0]              since, next_since;     // cycles since read data changed
  logic                    k_q, next_k_q;         // last K level
  logic [LANE_W*LANES-1:0] dq_q, next_dq_q;       // last read data
  logic                    src_pos, src_neg;      // clocks the echoes follow
  logic                    rd_ev;                 // read request at a K rise

  assign src_pos = i_single_clock ? i_k : i_c;
  assign src_neg = i_single_clock ? i_k_n : i_c_n;
  assign rd_ev = i_k && !k_q && i_cycle_request_n == DTS_REQ_ON && i_rw == DTS_DIR_READ;

  // next helper values
  always_comb begin
    next_k_q     = i_k;
    next_dq_q    = o_dq;
    next_settle  = (settle == 4'hF) ? settle : settle + 4'h1;
    next_rd_hist = {rd_hist[30:0], rd_ev};
    next_oe_run  = o_dq_oe ? oe_run + 6'h1 : 6'h0;
    next_since   = (o_dq != dq_q) ? 3'h0 : ((since == 3'h7) ? since : since + 3'h1);
    if (i_reset) begin
      next_settle  = 4'h0;
      next_rd_hist = 32'h0;
    end
  end

  // register helpers
  always_ff @(posedge i_mclk) begin
    k_q     <= next_k_q;
    dq_q    <= next_dq_q;
    settle  <= next_settle;
    rd_hist <= next_rd_hist;
    oe_run  <= next_oe_run;
    since   <= next_since;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  property p_echo_pos;
    settle == 4'hF |-> o_returned_strobe_pos == $past(src_pos, 3) || o_returned_strobe_pos == $past(src_pos, 4);
  endproperty
  property p_echo_neg;
    settle == 4'hF |-> o_returned_strobe_neg == $past(src_neg, 3) || o_returned_strobe_neg == $past(src_neg, 4);
  endproperty
  property p_read_latency;
    $rose(o_dq_oe) |-> (i_pll_disable_n ? |rd_hist[17:13] : |rd_hist[13:9]);
  endproperty
  property p_word_hold;
    $rose(o_dq_oe) |=> $stable(o_dq) [*3] ##1 o_dq_oe;
  endproperty
  property p_oe_run;
    $fell(o_dq_oe) |-> oe_run[2:0] == 3'h0 && oe_run != 6'h0;
  endproperty
  property p_word_gap;
    o_dq_oe && $past(o_dq_oe) && o_dq != dq_q |-> since == 3'h3;
  endproperty
  property p_launch_edge;
    $rose(o_dq_oe) |-> (i_pll_disable_n ? o_returned_strobe_neg : o_returned_strobe_pos);
  endproperty
  property p_idle_release;
    rd_hist == 32'h0 |-> !o_dq_oe;
  endproperty

  a_echo_pos:
    assert property (p_echo_pos) else $error("positive echo off its clock");
  a_echo_neg:
    assert property (p_echo_neg) else $error("negative echo off its clock");
  a_read_latency:
    assert property (p_read_latency) else $error("read data at wrong latency");
  a_word_hold:
    assert property (p_word_hold) else $error("first word not held until second");
  a_oe_run:
    assert property (p_oe_run) else $error("drive run not whole bursts");
  a_word_gap:
    assert property (p_word_gap) else $error("read word changed off a launch edge");
  a_launch_edge:
    assert property (p_launch_edge) else $error("first word on wrong launch edge");
  a_idle_release:
    assert property (p_idle_release) else $error("bus driven with no read pending");

  c_read_loop_on: cover property ($rose(o_dq_oe) && i_pll_disable_n);
  c_read_loop_off: cover property ($rose(o_dq_oe) && !i_pll_disable_n);
  c_read_single: cover property ($rose(o_dq_oe) && i_single_clock);
endmodule

// >>> dv/dts_ctl_model.sv
// ==========================================================
// memory controller model: free link clock, requests, write data
module dts_ctl_model
  import dts_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock
  input  wire logic                            i_mclk,
  // link clock pair
  output logic                                 o_k,
  output logic                                 o_k_n,
  // request and write data
  output logic                                 o_cycle_request_n,
  output logic                                 o_rw,
  output logic [ADDR_W-2:0]                    o_addr_upper,
  output logic                                 o_burst_start_bit,
  output logic [DTS_LANES-1:0]                 o_byte_lane_select_n,
  output logic [DTS_LANE_W*DTS_LANES-1:0]      o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DW = DTS_LANE_W * DTS_LANES;
  typedef struct packed {
    logic                 valid;
    logic                 rw;
    logic [ADDR_W-1:0]    addr;
    logic [DTS_LANES-1:0] l0, l1;
    logic [DW-1:0]        d0, d1;
  } dts_cmd_s;
  dts_cmd_s cmd_q[$];    // commands waiting for a K period
  dts_cmd_s cur  = '0;   // command on the pins
  int       ph   = 7;    // mclk position in the 8-cycle link period
  int       seed = 46;   // fixed seed for junk on idle pins

  // queue one burst
  task automatic issue(input logic rw_v, input logic [ADDR_W-1:0] a, input logic [DTS_LANES-1:0] l0, l1,
                       input logic [DW-1:0] d0, d1);
    cmd_q.push_back('{1'b1, rw_v, a, l0, l1, d0, d1});
  endtask

  initial begin
    {o_k, o_cycle_request_n, o_rw, o_addr_upper, o_burst_start_bit} = '0;
    o_k_n = 1'b1;
    o_byte_lane_select_n = '1;
    o_dq = '0;
  end

  // pins move 2 mclk before and after each link edge
  always @(posedge i_mclk) begin
    ph = (ph + 1) % 8;
    o_k   <= (ph < 4);
    o_k_n <= (ph >= 4);
    if (ph == 6)
      cur = (cmd_q.size() != 0) ? cmd_q.pop_front() : '0;
    if (ph == 6 || ph == 2) begin
      o_cycle_request_n <= !(cur.valid && ph == 6);
      o_rw <= (cur.valid && ph == 6) ? cur.rw : 1'($random(seed));
      {o_addr_upper, o_burst_start_bit} <= (cur.valid && ph == 6) ? cur.addr : ADDR_W'($random(seed));
    end
    // released bus changes every cycle
    if (!(cur.valid && cur.rw != DTS_DIR_READ)) begin
      o_dq <= DW'({$random(seed), $random(seed)});
      o_byte_lane_select_n <= DTS_LANES'($random(seed));
    end else if (ph == 6) begin
      o_dq <= cur.d0;
      o_byte_lane_select_n <= cur.l0;
    end else if (ph == 2) begin
      o_dq <= cur.d1;
      o_byte_lane_select_n <= cur.l1;
    end
  end
endmodule

// >>> dv/dts_sram_port_test.sv
module dts_sram_port_test
  import dts_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  localparam int AW = 8;                       // small array for a short run
  localparam int DW = DTS_LANE_W * DTS_LANES;
  logic                 i_mclk = 1'b0;
  logic                 i_reset = 1'b1;
  logic                 i_single_clock = 1'b0;
  logic                 i_pll_disable_n = 1'b1;
  logic                 k, k_n, req_n, rw, a0, o_dq_oe, echo_pos, echo_neg, oe_q;
  logic [AW-2:0]        addr_upper;
  logic [DTS_LANES-1:0] lanes_n;
  logic [DW-1:0]        ctl_dq, o_dq, dq_bus;
  logic [DW-1:0]        mem [logic [AW-1:0]];  // expected array contents
  logic [DW-1:0]        exp_q [$];             // expected read words in order
  logic [AW-1:0]        adr [6];               // addresses of one batch
  int                   failures = 0;
  int                   n_checks = 0;
  int                   seed = 46;
  int                   gap = 0;
  int                   i, m;

  always #50 i_mclk = ~i_mclk;
  assign dq_bus = o_dq_oe ? o_dq : ctl_dq;     // shared data wire

  dts_sram_port #(.ADDR_W(AW)) dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_k(k), .i_k_n(k_n),
    .i_c(i_single_clock ? 1'b0 : k), .i_c_n(i_single_clock ? 1'b1 : k_n),
    .i_single_clock(i_single_clock), .i_pll_disable_n(i_pll_disable_n), .i_cycle_request_n(req_n),
    .i_rw(rw), .i_addr_upper(addr_upper), .i_burst_start_bit(a0), .i_byte_lane_select_n(lanes_n),
    .i_dq(dq_bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_returned_strobe_pos(echo_pos), .o_returned_strobe_neg(echo_neg));

  dts_ctl_model #(.ADDR_W(AW)) u_ctl (
    .i_mclk(i_mclk), .o_k(k), .o_k_n(k_n), .o_cycle_request_n(req_n), .o_rw(rw),
    .o_addr_upper(addr_upper), .o_burst_start_bit(a0), .o_byte_lane_select_n(lanes_n), .o_dq(ctl_dq));

  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // selected lanes take new data, others keep old
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, nw, input logic [DTS_LANES-1:0] sel_n);
    merge = old;
    for (int l = 0; l < DTS_LANES; l++)
      if (sel_n[l] == DTS_LANE_ON)
        merge[l*DTS_LANE_W +: DTS_LANE_W] = nw[l*DTS_LANE_W +: DTS_LANE_W];
  endfunction

  // one burst with random data; model updated in order
  task automatic op(input logic rw_v, input logic [AW-1:0] a, input logic [DTS_LANES-1:0] l0, l1);
    logic [DW-1:0] d0, d1;
    logic [AW-1:0] b;
    d0 = DW'({$random(seed), $random(seed)});
    d1 = DW'({$random(seed), $random(seed)});
    b = {a[AW-1:1], ~a[0]};
    if (rw_v == DTS_DIR_READ) begin
      exp_q.push_back(mem[a]);
      exp_q.push_back(mem[b]);
    end else begin
      mem[a] = merge(mem.exists(a) ? mem[a] : 'x, d0, l0);
      mem[b] = merge(mem.exists(b) ? mem[b] : 'x, d1, l1);
    end
    u_ctl.issue(rw_v, a, l0, l1, d0, d1);
  endtask

  // drain commands and reads, then the bus must be released
  task automatic flush();
    for (i = 0; i < 3000 && (u_ctl.cmd_q.size() != 0 || exp_q.size() != 0); i++)
      @(posedge i_mclk);
    if (i == 3000) begin
      failures++;
      end_sim();
    end
    repeat (40) @(posedge i_mclk);
    @(negedge i_mclk);
    check(DW'(o_dq_oe), '0);
  endtask

  // each read word appears on oe rise, then every 4 cycles
  always @(negedge i_mclk) begin
    gap = (o_dq_oe === 1'b1 && (oe_q !== 1'b1 || gap == 3)) ? 0 : gap + 1;
    oe_q = o_dq_oe;
    if (o_dq_oe === 1'b1 && gap == 0)
      check(o_dq, exp_q.size() != 0 ? exp_q.pop_front() : ~o_dq);
  end

  initial begin
    for (m = 0; m < 4; m++) begin
      @(posedge i_mclk);
      i_reset <= 1'b1;
      i_single_clock <= m[1];
      i_pll_disable_n <= ~m[0];
      repeat (8) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (8) @(posedge i_mclk);
      for (int j = 0; j < 6; j++) begin
        adr[j] = AW'($random(seed));
        op(1'b0, adr[j], '0, '0);
      end
      for (int j = 0; j < 6; j++)
        op(1'b0, adr[j] ^ AW'(j % 2), j == 0 ? '1 : DTS_LANES'($random(seed)), DTS_LANES'($random(seed)));
      flush();
      for (int j = 0; j < 6; j++)
        op(1'b1, adr[j] ^ AW'(j / 3), DTS_LANES'($random(seed)), '0);
      flush();
    end
    end_sim();
  end
endmodule

bind dts_sram_port dts_sram_port_monitor #(.LANE_W(LANE_W), .LANES(LANES)) u_mon (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_k(i_k), .i_k_n(i_k_n), .i_c(i_c), .i_c_n(i_c_n),
  .i_single_clock(i_single_clock), .i_pll_disable_n(i_pll_disable_n), .i_cycle_request_n(i_cycle_request_n),
  .i_rw(i_rw), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_returned_strobe_pos(o_returned_strobe_pos),
  .o_returned_strobe_neg(o_returned_strobe_neg));
